/* verilog/stpatt_ctrl.sv */
// Purpose: host that programs a 5-bit step attenuator over its pins
// Assumes: 100 MHz clock; the host makes the serial clock by division
// Notes: registers reached over classic wishbone in stpatt_wbregs
`timescale 1ns/1ps
`include "stpatt_params.svh"
// Operation
// - serial power-up: host drives all five parallel inputs low
// - before first move to parallel, host loads a serial word with D7 low
// - parallel power-up: parallel inputs low before serial, until serial load
// - the mode-change sequence runs once; afterwards modes switch freely
// - latched parallel: strobe low while bits change, pulse high then low
// - direct parallel: strobe held high so inputs pass straight through
// - interface select low picks parallel, high picks serial
// - serial word is attenuation in dB times four, in binary
module stpatt_ctrl #(
    parameter int unsigned PUP_CYC = `STP_PUP_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // attenuator pins
    output logic ps_sel_o,
    output logic [4:0] parallel_atten_inputs_o,
    output logic ser_data_o,
    output logic ser_clk_o,
    output logic latch_strobe_o
);
    import stpatt_pkg::*;

    localparam logic [15:0] HALF_CYC = 16'(`STP_SCLK_HALF_CYC);
    localparam logic [15:0] STB_CYC = 16'(`STP_LEPW_CYC);
    localparam logic [15:0] SETUP_CYC = 16'(`STP_DISU_CYC);
    localparam logic [15:0] PS_CYC = 16'(`STP_PSSU_CYC);

    stpatt_ctl_t s_r;
    stpatt_ctl_t s_nxt;
    logic mode_req;
    logic direct;
    logic [4:0] atten;
    logic atten_wr;
    logic [31:0] status;

    stpatt_wbregs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .status_i(status),
        .mode_o(mode_req),
        .direct_o(direct),
        .atten_o(atten),
        .atten_wr_o(atten_wr)
    );

    // half-dB code to serial word: dB*4 = code*2, top two bits zero
    function automatic logic [7:0] atten_word(input logic [4:0] code);
        atten_word = {2'b00, code, 1'b0};
    endfunction

    always_comb begin
        s_nxt = s_r;
        // set wins over the clear taken below
        if (atten_wr) begin
            s_nxt.atten_pend = 1'b1;
        end
        case (s_r.st)
            ST_PUP: begin
                // no programming while the part may still be settling
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                s_nxt.strobe = !s_r.ps && direct;
                if (mode_req != s_r.ps) begin
                    if (!mode_req && !s_r.done) begin
                        // first move to parallel: load a word with D7 low first
                        s_nxt.code = atten;
                        s_nxt.word = atten_word(atten);
                        s_nxt.after_sw = 1'b1;
                        s_nxt.bitn = 3'h0;
                        s_nxt.sdat = s_nxt.word[0];
                        s_nxt.sclk = 1'b0;
                        s_nxt.strobe = 1'b0;
                        s_nxt.cnt = HALF_CYC;
                        s_nxt.st = ST_BIT_LO;
                    end else if (!mode_req) begin
                        s_nxt.ps = 1'b0;
                        s_nxt.cnt = PS_CYC;
                        s_nxt.st = ST_SWITCH;
                    end else begin
                        // inputs low before serial is selected
                        s_nxt.par = 5'h00;
                        s_nxt.strobe = 1'b0;
                        s_nxt.after_sw = 1'b1;
                        s_nxt.cnt = PS_CYC;
                        s_nxt.st = ST_PSET;
                    end
                end else if (s_r.atten_pend) begin
                    s_nxt.atten_pend = atten_wr;
                    s_nxt.code = atten;
                    s_nxt.after_sw = 1'b0;
                    if (s_r.ps) begin
                        s_nxt.word = atten_word(atten);
                        s_nxt.bitn = 3'h0;
                        s_nxt.sdat = s_nxt.word[0];
                        s_nxt.sclk = 1'b0;
                        s_nxt.cnt = HALF_CYC;
                        s_nxt.st = ST_BIT_LO;
                    end else begin
                        // strobe stays low in latched mode while bits change
                        s_nxt.par = atten;
                        s_nxt.cnt = SETUP_CYC;
                        s_nxt.st = ST_PSET;
                    end
                end
            end
            ST_PSET: begin
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else if (s_r.after_sw) begin
                    s_nxt.after_sw = 1'b0;
                    s_nxt.ps = !s_r.ps;
                    s_nxt.cnt = PS_CYC;
                    s_nxt.st = ST_SWITCH;
                end else if (s_r.strobe) begin
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.strobe = 1'b1;
                    s_nxt.cnt = STB_CYC;
                    s_nxt.st = ST_STB_HI;
                end
            end
            ST_SWITCH: begin
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else if (s_r.ps && !s_r.done) begin
                    // inputs are still low; now the clearing serial load
                    s_nxt.word = atten_word(s_r.code);
                    s_nxt.bitn = 3'h0;
                    s_nxt.sdat = s_nxt.word[0];
                    s_nxt.sclk = 1'b0;
                    s_nxt.cnt = HALF_CYC;
                    s_nxt.st = ST_BIT_LO;
                end else begin
                    // parallel pins must be redriven with the current code
                    s_nxt.atten_pend = !s_r.ps || s_nxt.atten_pend;
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_BIT_LO: begin
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else begin
                    s_nxt.sclk = 1'b1;
                    s_nxt.cnt = HALF_CYC;
                    s_nxt.st = ST_BIT_HI;
                end
            end
            ST_BIT_HI: begin
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else begin
                    s_nxt.sclk = 1'b0;
                    s_nxt.cnt = HALF_CYC;
                    if (s_r.bitn == 3'h7) begin
                        s_nxt.strobe = 1'b1;
                        s_nxt.cnt = STB_CYC;
                        s_nxt.st = ST_STB_HI;
                    end else begin
                        s_nxt.bitn = s_r.bitn + 3'h1;
                        s_nxt.sdat = s_r.word[s_r.bitn + 3'h1];
                        s_nxt.st = ST_BIT_LO;
                    end
                end
            end
            ST_STB_HI: begin
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else begin
                    s_nxt.strobe = 1'b0;
                    s_nxt.cnt = STB_CYC;
                    s_nxt.st = ST_STB_LO;
                end
            end
            ST_STB_LO: begin
                if (s_r.cnt != 16'h0) begin
                    s_nxt.cnt = s_r.cnt - 16'h1;
                end else begin
                    // in serial mode a word with D7 low has now been latched
                    s_nxt.done = s_r.done || s_r.ps;
                    if (s_r.after_sw) begin
                        s_nxt.after_sw = 1'b0;
                        s_nxt.ps = !s_r.ps;
                        s_nxt.cnt = PS_CYC;
                        s_nxt.st = ST_SWITCH;
                    end else begin
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // parallel inputs low whatever mode the part powers up in
            s_r <= '{st: ST_PUP, cnt: 16'(PUP_CYC), bitn: 3'h0, word: 8'h00,
                     ps: `STP_CTRL_MODE_RST, par: 5'h00, sdat: 1'b0, sclk: 1'b0,
                     strobe: 1'b0, done: 1'b0, after_sw: 1'b0, atten_pend: 1'b0,
                     code: `STP_ATTEN_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ps_sel_o = s_r.ps;
    assign parallel_atten_inputs_o = s_r.par;
    assign ser_data_o = s_r.sdat;
    assign ser_clk_o = s_r.sclk;
    assign latch_strobe_o = s_r.strobe;
    assign status = {20'h0, s_r.st != ST_PUP,
                     (s_r.st != ST_IDLE) || s_r.atten_pend || (mode_req != s_r.ps),
                     s_r.done, s_r.ps, 3'h0, s_r.code};

    property p_ser_par_low;
        @(posedge clk_i) disable iff (rst_i) s_r.ps |-> s_r.par == 5'h00;
    endproperty
    a_ser_par_low: assert property (p_ser_par_low)
        else $error("parallel inputs not low in serial mode");

    // a pending move to serial drops the strobe on purpose
    property p_direct_strobe;
        @(posedge clk_i) disable iff (rst_i)
            (s_r.st == ST_IDLE) && !s_r.ps && !mode_req && direct |=> s_r.strobe;
    endproperty
    a_direct_strobe: assert property (p_direct_strobe)
        else $error("strobe not high in direct parallel mode");

    property p_strobe_pulse;
        @(posedge clk_i) disable iff (rst_i)
            $rose(s_r.strobe) && (s_r.st == ST_STB_HI) |-> s_r.strobe [*4] ##1 !s_r.strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("latch strobe pulse width wrong");

    property p_sclk_high;
        @(posedge clk_i) disable iff (rst_i) $rose(s_r.sclk) |-> s_r.sclk [*6] ##1 !s_r.sclk;
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high time wrong");

    property p_sdat_stable;
        @(posedge clk_i) disable iff (rst_i)
            s_r.sclk || s_r.strobe |-> $stable(s_r.sdat) && !(s_r.sclk && s_r.strobe);
    endproperty
    a_sdat_stable: assert property (p_sdat_stable)
        else $error("serial data moved around clock or strobe");

    property p_d7_low;
        @(posedge clk_i) disable iff (rst_i)
            (s_r.st == ST_BIT_LO) && (s_r.bitn == 3'h7) |-> !s_r.sdat;
    endproperty
    a_d7_low: assert property (p_d7_low)
        else $error("serial word has D7 set");

    property p_to_parallel;
        @(posedge clk_i) disable iff (rst_i) $fell(s_r.ps) |-> s_r.done;
    endproperty
    a_to_parallel: assert property (p_to_parallel)
        else $error("parallel selected before clearing serial load");

    property p_to_serial;
        @(posedge clk_i) disable iff (rst_i) $rose(s_r.ps) |-> $past(s_r.par) == 5'h00;
    endproperty
    a_to_serial: assert property (p_to_serial)
        else $error("serial selected with parallel inputs high");

    property p_done_sticky;
        @(posedge clk_i) disable iff (rst_i) s_r.done |=> s_r.done;
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("sequence-done flag dropped");

    property p_pup_quiet;
        @(posedge clk_i) disable iff (rst_i)
            s_r.st == ST_PUP |=> $stable(s_r.ps) && !s_r.sclk && !s_r.strobe;
    endproperty
    a_pup_quiet: assert property (p_pup_quiet)
        else $error("pins moved during power-up delay");
endmodule

/* verilog/stpatt_params.svh */
// Purpose: constants for the step attenuator host controller
// Assumes: 100 MHz system clock
// Notes: timing counts derive from the printed times
`ifndef STPATT_PARAMS_SVH
`define STPATT_PARAMS_SVH

// register byte offsets
`define STP_ADR_CTRL 8'h00
`define STP_ADR_ATTEN 8'h04
`define STP_ADR_STATUS 8'h08

// control fields and reset values
`define STP_CTRL_MODE_BIT 0
`define STP_CTRL_DIRECT_BIT 1
`define STP_CTRL_MODE_RST 1'h1
`define STP_CTRL_DIRECT_RST 1'h0
`define STP_ATTEN_RST 5'h1F

// status fields
`define STP_ST_CODE_LSB 0
`define STP_ST_MODE_BIT 8
`define STP_ST_DONE_BIT 9
`define STP_ST_BUSY_BIT 10
`define STP_ST_PUP_BIT 11

// timing, in ns and us, and derived cycle counts
`define STP_CLK_NS 10
`define STP_SCLK_HALF_NS 50
`define STP_LEPW_NS 30
`define STP_DISU_NS 100
`define STP_PSSU_NS 100
`define STP_PUP_US 400
`define STP_SCLK_HALF_CYC ((`STP_SCLK_HALF_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_LEPW_CYC ((`STP_LEPW_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_DISU_CYC ((`STP_DISU_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_PSSU_CYC ((`STP_PSSU_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_PUP_CYC ((`STP_PUP_US * 1000 + `STP_CLK_NS - 1) / `STP_CLK_NS)

`endif

/* verilog/stpatt_pkg.sv */
// Purpose: types shared by the step attenuator host controller
// Assumes: nothing
// Notes: state of each module is one packed struct
package stpatt_pkg;
    typedef enum logic [3:0] {
        ST_PUP, ST_IDLE, ST_PSET, ST_SWITCH, ST_BIT_LO, ST_BIT_HI, ST_STB_HI, ST_STB_LO
    } stpatt_state_t;

    typedef struct packed {
        stpatt_state_t st;
        logic [15:0] cnt;
        logic [2:0] bitn;
        logic [7:0] word;
        logic ps;
        logic [4:0] par;
        logic sdat;
        logic sclk;
        logic strobe;
        logic done;
        logic after_sw;
        logic atten_pend;
        logic [4:0] code;
    } stpatt_ctl_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic mode;
        logic direct;
        logic [4:0] atten;
        logic atten_wr;
    } stpatt_regs_t;
endpackage

/* verilog/stpatt_wbregs.sv */
// Purpose: classic wishbone slave holding the controller's registers
// Assumes: single-cycle classic transfers, 32-bit data
// Notes: unmapped reads return zero and writes are dropped, both acked
`timescale 1ns/1ps
`include "stpatt_params.svh"
module stpatt_wbregs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // to and from the sequencer
    input wire logic [31:0] status_i,
    output logic mode_o,
    output logic direct_o,
    output logic [4:0] atten_o,
    output logic atten_wr_o
);
    import stpatt_pkg::*;

    stpatt_regs_t r_r;
    stpatt_regs_t r_nxt;

    function automatic logic adr_is(input logic [7:0] adr, input logic [7:0] off);
        adr_is = (adr == off);
    endfunction

    always_comb begin
        logic take;
        take = wb_cyc_i && wb_stb_i && !r_r.ack;
        r_nxt = r_r;
        r_nxt.ack = take;
        r_nxt.atten_wr = 1'b0;
        if (take) begin
            r_nxt.dat = 32'h0;
            if (wb_we_i && wb_sel_i[0]) begin
                if (adr_is(wb_adr_i, `STP_ADR_CTRL)) begin
                    r_nxt.mode = wb_dat_i[`STP_CTRL_MODE_BIT];
                    r_nxt.direct = wb_dat_i[`STP_CTRL_DIRECT_BIT];
                end else if (adr_is(wb_adr_i, `STP_ADR_ATTEN)) begin
                    r_nxt.atten = wb_dat_i[4:0];
                    r_nxt.atten_wr = 1'b1;
                end
            end else if (!wb_we_i) begin
                if (adr_is(wb_adr_i, `STP_ADR_CTRL)) begin
                    r_nxt.dat = {30'h0, r_r.direct, r_r.mode};
                end else if (adr_is(wb_adr_i, `STP_ADR_ATTEN)) begin
                    r_nxt.dat = {27'h0, r_r.atten};
                end else if (adr_is(wb_adr_i, `STP_ADR_STATUS)) begin
                    r_nxt.dat = status_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_r <= '{ack: 1'b0, dat: 32'h0, mode: `STP_CTRL_MODE_RST,
                     direct: `STP_CTRL_DIRECT_RST, atten: `STP_ATTEN_RST, atten_wr: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign wb_ack_o = r_r.ack;
    assign wb_dat_o = r_r.dat;
    assign mode_o = r_r.mode;
    assign direct_o = r_r.direct;
    assign atten_o = r_r.atten;
    assign atten_wr_o = r_r.atten_wr;
endmodule

/* tb/stpatt_dev_model.sv */
// Purpose: behavioural model of the 5-bit step attenuator's control pins
// Assumes: the bench clock stands in for the device's internal settling
// Notes: viol_o is sticky and flags a host that breaks power-up sequencing
`timescale 1ns/1ps
module stpatt_dev_model #(
    parameter int unsigned PUP_CYC = 20
) (
    // bench clock and power-up
    input wire logic clk_i,
    input wire logic rst_i,
    // control pins
    input wire logic ps_sel_i,
    input wire logic [4:0] parallel_atten_inputs_i,
    input wire logic ser_data_i,
    input wire logic ser_clk_i,
    input wire logic latch_strobe_i,
    // observed state
    output logic [4:0] atten_o,
    output logic [7:0] word_o,
    output logic d7_clear_o,
    output logic viol_o
);
    logic [7:0] shift_r;
    logic [4:0] pins;
    logic pup_serial_r;
    int unsigned pup_left;
    // floating pins read low through the on-chip pull-down
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pins[i] = (parallel_atten_inputs_i[i] === 1'b1);
        end
    end
    // first bit lands in bit 0 after eight shifts
    always @(posedge ser_clk_i) begin
        if (ps_sel_i === 1'b1 && latch_strobe_i === 1'b0) begin
            shift_r <= {ser_data_i, shift_r[7:1]};
        end
    end
    assign word_o = shift_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            atten_o <= 5'h1F;
            pup_left <= PUP_CYC;
            pup_serial_r <= ps_sel_i;
            d7_clear_o <= 1'b0;
            viol_o <= 1'b0;
        end else begin
            // max attenuation held through the power-up delay
            if (pup_left != 0) begin
                pup_left <= pup_left - 1;
            end else if (latch_strobe_i === 1'b1) begin
                if (ps_sel_i === 1'b1) begin
                    atten_o <= shift_r[5:1];
                    d7_clear_o <= d7_clear_o | ~shift_r[7];
                end else begin
                    atten_o <= pins;
                end
            end
            if (!d7_clear_o && ps_sel_i === 1'b1 && pins != 5'h00) begin
                viol_o <= 1'b1;
            end
            if (!d7_clear_o && pup_serial_r && ps_sel_i === 1'b0) begin
                viol_o <= 1'b1;
            end
        end
    end
endmodule

/* tb/tb_stpatt_ctrl.sv */
// Purpose: self-checking bench for the step attenuator host controller
// Assumes: device model on the pins; power-up wait shortened to 20 cycles
// Notes: completion is found by polling status, never by a fixed wait
`timescale 1ns/1ps
`include "stpatt_params.svh"
module tb_stpatt_ctrl;
    localparam logic [31:0] ST_SEL = 32'h0000_0100;
    localparam logic [31:0] ST_DONE = 32'h0000_0200;
    localparam logic [31:0] ST_BUSY = 32'h0000_0400;
    localparam logic [31:0] ST_PUP = 32'h0000_0800;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, ps_sel, sdat, sclk, strobe, d7_clear, viol;
    logic [4:0] par, atten;
    logic [7:0] word;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    stpatt_ctrl #(.PUP_CYC(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ps_sel_o(ps_sel),
        .parallel_atten_inputs_o(par), .ser_data_o(sdat), .ser_clk_o(sclk),
        .latch_strobe_o(strobe));
    stpatt_dev_model #(.PUP_CYC(20)) dev (.clk_i(clk_i), .rst_i(rst_i), .ps_sel_i(ps_sel),
        .parallel_atten_inputs_i(par), .ser_data_i(sdat), .ser_clk_i(sclk),
        .latch_strobe_i(strobe), .atten_o(atten), .word_o(word), .d7_clear_o(d7_clear),
        .viol_o(viol));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // request held until ack is sampled high; no own limit, watchdog ends a hang
    task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [3:0] sel,
                           input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(a, 1'b1, 4'hF, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb_xfer(a, 1'b0, 4'h0, 32'h0000_0000, q);
    endtask
    task automatic poll(input logic [31:0] mask, input logic [31:0] val);
        logic [31:0] q;
        int n;
        n = 0;
        rd(`STP_ADR_STATUS, q);
        while ((q & mask) !== val && n < 400) begin
            rd(`STP_ADR_STATUS, q);
            n++;
        end
        check(q & mask, val, "status");
    endtask
    task automatic t_reset();
        logic [31:0] q;
        check({ps_sel, sclk, strobe, par}, {3'h4, 5'h00}, "pins after reset");
        rd(`STP_ADR_CTRL, q);
        check(q, 32'h0000_0001, "ctrl reset");
        rd(`STP_ADR_ATTEN, q);
        check(q, 32'h0000_001F, "atten reset");
        wr(8'h0C, 32'h0000_0000);
        wb_xfer(`STP_ADR_ATTEN, 1'b1, 4'h0, 32'h0000_0005, q);
        rd(8'h0C, q);
        check(q, 32'h0000_0000, "unmapped read");
        rd(`STP_ADR_ATTEN, q);
        check(q, 32'h0000_001F, "write without byte select");
        poll(ST_PUP | ST_BUSY, ST_PUP);
        check(atten, 5'h1F, "device after power-up");
    endtask
    task automatic t_serial(input logic [4:0] code);
        wr(`STP_ADR_ATTEN, {27'h0, code});
        poll(ST_BUSY | 32'h0000_001F, {27'h0, code});
        check(atten, code, "serial load");
        check(word, {2'b00, code, 1'b0}, "serial word");
        check(par, 5'h00, "parallel pins in serial");
        check(viol, 1'b0, "sequencing");
    endtask
    // runs before any serial word, so the host's own clearing load is exercised
    task automatic t_parallel();
        wr(`STP_ADR_CTRL, 32'h0000_0000);
        poll(ST_SEL | ST_DONE | ST_BUSY, ST_DONE);
        check(ps_sel, 1'b0, "select parallel");
        check({d7_clear, viol}, 2'b10, "serial word before parallel");
        check(word, 8'h3E, "clearing word of 15.5 dB");
        check(par, 5'h1F, "code re-driven");
        wr(`STP_ADR_ATTEN, 32'h0000_000A);
        poll(ST_BUSY | 32'h0000_001F, 32'h0000_000A);
        check(atten, 5'h0A, "latched parallel");
        check(strobe, 1'b0, "strobe back low");
        wr(`STP_ADR_CTRL, 32'h0000_0002);
        wr(`STP_ADR_ATTEN, 32'h0000_0015);
        poll(ST_BUSY | 32'h0000_001F, 32'h0000_0015);
        check(strobe, 1'b1, "direct strobe high");
        check(atten, 5'h15, "direct parallel");
    endtask
    task automatic t_back();
        wr(`STP_ADR_CTRL, 32'h0000_0001);
        poll(ST_SEL | ST_BUSY, ST_SEL);
        check({ps_sel, par}, {1'b1, 5'h00}, "back to serial");
        t_serial(5'h19);
        t_serial(5'h03);
        wr(`STP_ADR_CTRL, 32'h0000_0000);
        poll(ST_SEL | ST_BUSY, 32'h0000_0000);
        check({ps_sel, par, viol}, {1'b0, 5'h03, 1'b0}, "free switch");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        check(atten, 5'h1F, "no change before first word");
        t_parallel();
        t_back();
        end_of_test();
    end
endmodule
